// [hw/lic_params.svh]
// Constants for the link impedance calibration register bank
// Function
// RULE_01 - Bank reached only through index register then data register.
// RULE_02 - One control register per link, indices 14h and 2Ch, same layout.
// RULE_03 - Status at 30h/38h and result at 34h/3Ch, per link.
// RULE_04 - Bits 2:0 weight n, default 2; avg moves by 2^-n toward sample.
// RULE_05 - Bit 8 run, default one; result refreshed while set.
// RULE_06 - Bit 9 enables common-mode termination calibration, default zero.
// RULE_07 - Bit 10 receive termination enable, default one, passed to PHY.
// RULE_08 - Bit 11 selects receive (0) or transmit (1) result.
// RULE_09 - Status bit 8 set whenever a new result is placed.
// RULE_10 - Acquired when average and sample differ by at most one; lost otherwise.
// RULE_11 - Result refreshed once every 1K core clocks while running.
// RULE_12 - Result carries the selected 5-bit impedance code.
// RULE_13 - Result resets to 0000FFFFh.
// RULE_14 - Both links hold separate state and run the same logic.
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH
`define LIC_INDEX_OFF 8'hd4
`define LIC_DATA_OFF 8'hd8
`define LIC_CTRL0_OFF 8'h14
`define LIC_CTRL1_OFF 8'h2c
`define LIC_STAT0_OFF 8'h30
`define LIC_RES0_OFF 8'h34
`define LIC_STAT1_OFF 8'h38
`define LIC_RES1_OFF 8'h3c
`define LIC_WEIGHT_LSB 0
`define LIC_RUN_BIT 8
`define LIC_CM_BIT 9
`define LIC_TERM_BIT 10
`define LIC_SEL_BIT 11
`define LIC_CTRL_RST 7'h2a
`define LIC_RESULT_RST 32'h0000_ffff
`define LIC_REFRESH_CLKS 1024
`endif

// [hw/lic_pkg.sv]
// Types shared by the link impedance calibration register bank
package lic_pkg;
    // Control fields of one link, as forwarded to the calibrator
    typedef struct packed {
        logic report_select;
        logic receive_termination_enable;
        logic common_mode_cal_enable;
        logic calibration_run;
        logic [2:0] averaging_weight;
    } lic_ctrl_t;
    // Raw impedance codes from the calibrator of one link
    typedef struct packed {
        logic [4:0] tx;
        logic [4:0] rx;
    } lic_sample_t;
    // One configuration space access
    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } lic_cfg_t;
endpackage

// [hw/lic_regs.sv]
// Indirect calibration register bank for two links
`timescale 1ns/1ps
`include "lic_params.svh"
module lic_regs
    import lic_pkg::*;
#(
    parameter int REFRESH_CYCLES = `LIC_REFRESH_CLKS,
    parameter logic [7:0] CAL_VERSION = 8'h5a // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire lic_cfg_t i_cfg,
    input wire lic_sample_t [1:0] i_cal_sample,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    output lic_ctrl_t [1:0] o_link_ctrl
);
    localparam int TW = $clog2(REFRESH_CYCLES);
    localparam logic [7:0] CTRL_OFF [2] = '{`LIC_CTRL0_OFF, `LIC_CTRL1_OFF};
    localparam logic [7:0] STAT_OFF [2] = '{`LIC_STAT0_OFF, `LIC_STAT1_OFF};
    localparam logic [7:0] RES_OFF [2] = '{`LIC_RES0_OFF, `LIC_RES1_OFF};

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Fixed point average step, 5 integer and 8 fraction bits
    function automatic logic [12:0] lic_avg_step(
        input logic [12:0] avg,
        input logic [4:0] s,
        input logic [2:0] n
    );
        logic [12:0] sf;
        sf = {s, 8'h00};
        lic_avg_step = avg - (avg >> n) + (sf >> n); // RULE_04
    endfunction

    // True when two codes differ by at most one
    function automatic logic lic_near(
        input logic [4:0] a,
        input logic [4:0] b
    );
        if (a > b) begin
            lic_near = (a - b) <= 5'h1;
        end else begin
            lic_near = (b - a) <= 5'h1;
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] index_reg, index_next;
    lic_ctrl_t [1:0] ctrl_reg, ctrl_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic data_hit;
    logic [1:0] stat_rd;
    logic [1:0] tick;
    lic_sample_t [1:0] s1_reg, s2_reg;
    logic [TW-1:0] timer_reg [2];
    logic [TW-1:0] timer_next [2];
    logic [12:0] avg_tx_reg [2];
    logic [12:0] avg_tx_next [2];
    logic [12:0] avg_rx_reg [2];
    logic [12:0] avg_rx_next [2];
    logic [1:0] have_reg, have_next;
    logic [1:0] done_reg, done_next;
    logic [1:0] acq_tx_reg, acq_tx_next;
    logic [1:0] lost_tx_reg, lost_tx_next;
    logic [1:0] acq_rx_reg, acq_rx_next;
    logic [1:0] lost_rx_reg, lost_rx_next;
    logic [31:0] result_reg [2];
    logic [31:0] result_next [2];

    // ----------------------------------------------------------------
    // Configuration access
    // ----------------------------------------------------------------

    // Decode index and data register, select indirect target
    always_comb begin
        index_next = index_reg;
        ctrl_next = ctrl_reg;
        ack_next = i_cfg.req;
        rdata_next = 32'h0000_0000;
        stat_rd = 2'b00;
        data_hit = i_cfg.req && (i_cfg.addr == `LIC_DATA_OFF); // RULE_01
        if (i_cfg.req && (i_cfg.addr == `LIC_INDEX_OFF)) begin // RULE_01
            if (i_cfg.wr) begin
                index_next = i_cfg.wdata[7:0];
            end else begin
                rdata_next = {24'h00_0000, index_reg};
            end
        end
        for (int l = 0; l < 2; l++) begin // RULE_14
            if (data_hit && (index_reg == CTRL_OFF[l])) begin // RULE_02
                if (i_cfg.wr) begin
                    ctrl_next[l].averaging_weight =
                        i_cfg.wdata[`LIC_WEIGHT_LSB +: 3]; // RULE_04
                    ctrl_next[l].calibration_run =
                        i_cfg.wdata[`LIC_RUN_BIT]; // RULE_05
                    ctrl_next[l].common_mode_cal_enable =
                        i_cfg.wdata[`LIC_CM_BIT]; // RULE_06
                    ctrl_next[l].receive_termination_enable =
                        i_cfg.wdata[`LIC_TERM_BIT]; // RULE_07
                    ctrl_next[l].report_select =
                        i_cfg.wdata[`LIC_SEL_BIT]; // RULE_08
                end else begin
                    rdata_next = {20'h0_0000,
                        ctrl_reg[l].report_select,
                        ctrl_reg[l].receive_termination_enable,
                        ctrl_reg[l].common_mode_cal_enable,
                        ctrl_reg[l].calibration_run,
                        5'h00,
                        ctrl_reg[l].averaging_weight};
                end
            end
            if (data_hit && !i_cfg.wr && (index_reg == STAT_OFF[l])) begin // RULE_03
                rdata_next = {19'h0_0000, lost_rx_reg[l], acq_rx_reg[l],
                    lost_tx_reg[l], acq_tx_reg[l], done_reg[l], CAL_VERSION};
                stat_rd[l] = 1'b1; // Reading status clears done
            end
            if (data_hit && !i_cfg.wr && (index_reg == RES_OFF[l])) begin // RULE_03
                rdata_next = result_reg[l];
            end
        end
    end

    // Register configuration state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            index_reg <= 8'h00;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            for (int l = 0; l < 2; l++) begin
                ctrl_reg[l] <= `LIC_CTRL_RST; // RULE_05
            end
        end else begin
            index_reg <= index_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------------------------------------------------------
    // Calibrator side
    // ----------------------------------------------------------------

    // Two-stage synchroniser on the calibrator codes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= i_cal_sample;
            s2_reg <= s1_reg;
        end
    end

    // Refresh timer, averaging and status per link
    always_comb begin
        for (int l = 0; l < 2; l++) begin // RULE_14
            tick[l] = ctrl_reg[l].calibration_run &&
                (timer_reg[l] == TW'(REFRESH_CYCLES - 1)); // RULE_11
            timer_next[l] = timer_reg[l] + 1'b1;
            if (!ctrl_reg[l].calibration_run || tick[l]) begin // RULE_05
                timer_next[l] = '0;
            end
            avg_tx_next[l] = avg_tx_reg[l];
            avg_rx_next[l] = avg_rx_reg[l];
            have_next[l] = have_reg[l];
            acq_tx_next[l] = acq_tx_reg[l];
            lost_tx_next[l] = lost_tx_reg[l];
            acq_rx_next[l] = acq_rx_reg[l];
            lost_rx_next[l] = lost_rx_reg[l];
            result_next[l] = result_reg[l];
            done_next[l] = done_reg[l] && !stat_rd[l];
            if (tick[l]) begin
                if (have_reg[l]) begin
                    avg_tx_next[l] = lic_avg_step(avg_tx_reg[l], s2_reg[l].tx,
                        ctrl_reg[l].averaging_weight); // RULE_04
                    avg_rx_next[l] = lic_avg_step(avg_rx_reg[l], s2_reg[l].rx,
                        ctrl_reg[l].averaging_weight); // RULE_04
                end else begin
                    avg_tx_next[l] = {s2_reg[l].tx, 8'h00}; // First sample seeds
                    avg_rx_next[l] = {s2_reg[l].rx, 8'h00};
                end
                have_next[l] = 1'b1;
                acq_tx_next[l] = lic_near(avg_tx_next[l][12:8], s2_reg[l].tx); // RULE_10
                lost_tx_next[l] = !acq_tx_next[l]; // RULE_10
                acq_rx_next[l] = lic_near(avg_rx_next[l][12:8], s2_reg[l].rx); // RULE_10
                lost_rx_next[l] = !acq_rx_next[l]; // RULE_10
                if (ctrl_reg[l].report_select) begin // RULE_08
                    result_next[l] = {27'h000_0000, avg_tx_next[l][12:8]}; // RULE_12
                end else begin
                    result_next[l] = {27'h000_0000, avg_rx_next[l][12:8]}; // RULE_12
                end
                done_next[l] = 1'b1; // RULE_09
            end
        end
    end

    // Register calibration state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            have_reg <= 2'b00;
            done_reg <= 2'b00;
            acq_tx_reg <= 2'b00;
            lost_tx_reg <= 2'b00;
            acq_rx_reg <= 2'b00;
            lost_rx_reg <= 2'b00;
            for (int l = 0; l < 2; l++) begin
                timer_reg[l] <= '0;
                avg_tx_reg[l] <= 13'h0000;
                avg_rx_reg[l] <= 13'h0000;
                result_reg[l] <= `LIC_RESULT_RST; // RULE_13
            end
        end else begin
            have_reg <= have_next;
            done_reg <= done_next;
            acq_tx_reg <= acq_tx_next;
            lost_tx_reg <= lost_tx_next;
            acq_rx_reg <= acq_rx_next;
            lost_rx_reg <= lost_rx_next;
            timer_reg <= timer_next;
            avg_tx_reg <= avg_tx_next;
            avg_rx_reg <= avg_rx_next;
            result_reg <= result_next;
        end
    end

    // Outputs straight from flops
    assign o_cfg_ack = ack_reg;
    assign o_cfg_rdata = rdata_reg;
    assign o_link_ctrl = ctrl_reg; // RULE_06 RULE_07

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_ack_follows: assert property (i_cfg.req |=> o_cfg_ack) // RULE_01
        else $error("access not acknowledged");
    a_ack_cause: assert property (o_cfg_ack |-> $past(i_cfg.req)) // RULE_01
        else $error("spurious acknowledge");
    a_ctrl_write: assert property (data_hit && i_cfg.wr &&
        index_reg == `LIC_CTRL1_OFF |=> o_link_ctrl[1].calibration_run ==
        $past(i_cfg.wdata[`LIC_RUN_BIT])) // RULE_02
        else $error("control write lost");
    a_result_read: assert property (data_hit && !i_cfg.wr &&
        index_reg == `LIC_RES0_OFF |=> o_cfg_rdata == $past(result_reg[0])) // RULE_03
        else $error("result read wrong");
    a_run_stop: assert property (!ctrl_reg[0].calibration_run |=>
        $stable(result_reg[0])) // RULE_05
        else $error("result moved while disabled");
    a_tick_gap: assert property (tick[0] |=> !tick[0] [*8]) // RULE_11
        else $error("refresh too frequent");
    a_done_set: assert property (tick[1] |=> done_reg[1]) // RULE_09
        else $error("done not set");
    a_done_cause: assert property ($rose(done_reg[0]) |-> $past(tick[0])) // RULE_09
        else $error("done without refresh");
    a_acq_value: assert property (tick[0] |=> acq_tx_reg[0] ==
        lic_near(avg_tx_reg[0][12:8], $past(s2_reg[0].tx))) // RULE_10
        else $error("acquired flag wrong");
    a_lost_excl: assert property (have_reg[0] |-> acq_rx_reg[0] != lost_rx_reg[0]) // RULE_10
        else $error("lost and acquired agree");
    a_result_sel: assert property (tick[0] && ctrl_reg[0].report_select |=>
        result_reg[0] == {27'h000_0000, avg_tx_reg[0][12:8]}) // RULE_12
        else $error("result not transmit code");

    // Bus side: index, idle data, link 1 status done bit and link 0 control
    a_index_write: assert property (i_cfg.req && i_cfg.wr && // RULE_01
        i_cfg.addr == `LIC_INDEX_OFF |=> index_reg == $past(i_cfg.wdata[7:0]))
        else $error("index write lost");
    a_rdata_idle: assert property (!i_cfg.req |=> o_cfg_rdata == 32'h0000_0000) // RULE_01
        else $error("read data not cleared");
    a_status_read: assert property (data_hit && !i_cfg.wr && // RULE_09
        index_reg == `LIC_STAT1_OFF |=> o_cfg_rdata[8] == $past(done_reg[1]))
        else $error("status done bit wrong");
    a_ctrl_weight: assert property (data_hit && i_cfg.wr && // RULE_04
        index_reg == `LIC_CTRL0_OFF |=> o_link_ctrl[0].averaging_weight ==
        $past(i_cfg.wdata[`LIC_WEIGHT_LSB +: 3]))
        else $error("weight write lost");

    // Refresh side: timer, flags and result between refreshes
    a_timer_hold: assert property (!ctrl_reg[1].calibration_run |=> // RULE_05
        timer_reg[1] == TW'(0))
        else $error("timer ran while disabled");
    a_tick_gap1: assert property (tick[1] |=> !tick[1] [*8]) // RULE_11
        else $error("link 1 refresh too frequent");
    a_result_hold: assert property (!tick[1] |=> $stable(result_reg[1])) // RULE_11
        else $error("result moved between refreshes");
    a_done_keep: assert property (done_reg[0] && !stat_rd[0] |=> done_reg[0]) // RULE_09
        else $error("done dropped without a read");
    a_lost_tx: assert property (have_reg[1] |-> acq_tx_reg[1] != lost_tx_reg[1]) // RULE_10
        else $error("transmit lost and acquired agree");
    a_result_rx: assert property (tick[1] && !ctrl_reg[1].report_select |=> // RULE_12
        result_reg[1] == {27'h000_0000, avg_rx_reg[1][12:8]})
        else $error("result not receive code");

    // Main scenarios the bench reaches
    c_refresh: cover property (tick[0] ##[0:64] tick[1]);
    c_status_clear: cover property (done_reg[0] && stat_rd[0] ##1 !done_reg[0]);
    c_acquired: cover property (acq_tx_reg[1] && acq_rx_reg[1]);
endmodule

// [verification/lic_cal_model.sv]
// Behavioural impedance calibrator that feeds codes to both links
`timescale 1ns/1ps
module lic_cal_model
    import lic_pkg::*;
(
    input wire logic i_clk,
    input wire lic_ctrl_t [1:0] i_link_ctrl,
    input wire lic_sample_t [1:0] i_target,
    output lic_sample_t [1:0] o_cal_sample
);
    bit loaded_reg = 1'b0;

    // Codes move only while a link is idle, so a running average sees a steady input;
    // the first edge loads them once, since both links leave reset already running
    always @(negedge i_clk) begin
        for (int l = 0; l < 2; l++) begin
            if (!loaded_reg || i_link_ctrl[l].calibration_run !== 1'b1) begin
                o_cal_sample[l] <= i_target[l];
            end
        end
        loaded_reg <= 1'b1;
    end
endmodule

// [verification/lic_regs_tb_top.sv]
// Self-checking bench for the link impedance calibration register bank
`timescale 1ns/1ps
`include "lic_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module lic_regs_tb_top
    import lic_pkg::*;
;
    localparam int REFRESH = 16;
    localparam logic [7:0] VER = 8'h3c; // Arbitrary value
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    lic_cfg_t cfg = '0;
    logic ack;
    logic [31:0] rdata;
    lic_ctrl_t [1:0] link_ctrl;
    lic_sample_t [1:0] target = {5'h16, 5'h09, 5'h16, 5'h09};
    lic_sample_t [1:0] sample;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rng = 32'h0000_ffb2;
    int avg [2][2];
    int code [2][2] = '{'{9, 22}, '{9, 22}};
    lic_ctrl_t exp_ctrl [2];
    logic [31:0] rd;

    always #5 i_clk = ~i_clk;

    lic_regs #(.REFRESH_CYCLES(REFRESH), .CAL_VERSION(VER)) u_dut (.i_clk(i_clk),
        .i_srst(i_srst), .i_cfg(cfg), .i_cal_sample(sample), .o_cfg_ack(ack),
        .o_cfg_rdata(rdata), .o_link_ctrl(link_ctrl));
    lic_cal_model u_cal (.i_clk(i_clk), .i_link_ctrl(link_ctrl), .i_target(target),
        .o_cal_sample(sample));

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [31:0] ctrl_img(lic_ctrl_t c);
        return {20'h0_0000, c.report_select, c.receive_termination_enable,
            c.common_mode_cal_enable, c.calibration_run, 5'h00, c.averaging_weight};
    endfunction

    // Expected status word from the reference averages
    function automatic logic [31:0] exp_stat(int l, logic done);
        logic at;
        logic ar;
        at = ((avg[l][1] >> 8) - code[l][1]) inside {[-1:1]};
        ar = ((avg[l][0] >> 8) - code[l][0]) inside {[-1:1]};
        return {19'h0_0000, !ar, ar, !at, at, done, VER};
    endfunction

    // One access: request held one cycle, answer taken in the next
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rv);
        @(negedge i_clk);
        cfg = '{req: 1'b1, wr: wr, addr: a, wdata: wd};
        @(negedge i_clk);
        `CHK(ack, 1'b1)
        rv = rdata;
        cfg.req = 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] nul;
        acc(1'b1, `LIC_INDEX_OFF, {24'h00_0000, idx}, nul);
        acc(1'b1, `LIC_DATA_OFF, d, nul);
    endtask

    task automatic reg_rd(input logic [7:0] idx, output logic [31:0] d);
        logic [31:0] nul;
        acc(1'b1, `LIC_INDEX_OFF, {24'h00_0000, idx}, nul);
        acc(1'b0, `LIC_DATA_OFF, 32'h0000_0000, d);
    endtask

    // Random control and codes, one refresh, then freeze and compare
    task automatic run_once(int l);
        lic_ctrl_t c;
        logic [31:0] st;
        logic [31:0] r;
        logic [7:0] ci;
        logic [7:0] si;
        logic [7:0] ri;
        ci = (l != 0) ? `LIC_CTRL1_OFF : `LIC_CTRL0_OFF;
        si = (l != 0) ? `LIC_STAT1_OFF : `LIC_STAT0_OFF;
        ri = (l != 0) ? `LIC_RES1_OFF : `LIC_RES0_OFF;
        r = xs();
        c = r[6:0];
        c.calibration_run = 1'b1;
        code[l][1] = int'(r[12:8]);
        code[l][0] = int'(r[20:16]);
        target[l] = {5'(code[l][1]), 5'(code[l][0])};
        repeat (4) @(negedge i_clk);
        reg_wr(ci, ctrl_img(c));
        exp_ctrl[l] = c;
        `CHK(link_ctrl, {exp_ctrl[1], exp_ctrl[0]})
        reg_rd(ci, st);
        `CHK(st, ctrl_img(c))
        st = 32'h0000_0000;
        for (int p = 0; p < 12 && st[8] !== 1'b1; p++) begin
            reg_rd(si, st);
        end
        for (int k = 0; k < 2; k++) begin
            avg[l][k] = avg[l][k] - (avg[l][k] >> c.averaging_weight)
                + ((code[l][k] << 8) >> c.averaging_weight);
        end
        `CHK(st, exp_stat(l, 1'b1))
        c.calibration_run = 1'b0;
        reg_wr(ci, ctrl_img(c));
        exp_ctrl[l] = c;
        `CHK(link_ctrl, {exp_ctrl[1], exp_ctrl[0]})
        repeat (3 * REFRESH) @(negedge i_clk);
        reg_rd(si, st);
        `CHK(st, exp_stat(l, 1'b0))
        reg_rd(ri, st);
        `CHK(st, {27'h000_0000, 5'(avg[l][c.report_select] >> 8)})
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #(20000 * 10);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        reg_rd(`LIC_RES0_OFF, rd);
        `CHK(rd, 32'h0000_ffff)
        reg_rd(`LIC_RES1_OFF, rd);
        `CHK(rd, 32'h0000_ffff)
        for (int l = 0; l < 2; l++) begin
            exp_ctrl[l] = 7'h2a;
            reg_rd((l != 0) ? `LIC_CTRL1_OFF : `LIC_CTRL0_OFF, rd);
            `CHK(rd, 32'h0000_0502)
        end
        `CHK(link_ctrl, {exp_ctrl[1], exp_ctrl[0]})
        repeat (3 * REFRESH) @(negedge i_clk);
        for (int l = 0; l < 2; l++) begin
            exp_ctrl[l].calibration_run = 1'b0;
            reg_wr((l != 0) ? `LIC_CTRL1_OFF : `LIC_CTRL0_OFF, ctrl_img(exp_ctrl[l]));
            avg[l][0] = code[l][0] << 8;
            avg[l][1] = code[l][1] << 8;
            reg_rd((l != 0) ? `LIC_STAT1_OFF : `LIC_STAT0_OFF, rd);
            `CHK(rd, exp_stat(l, 1'b1))
        end
        $display("test reset done");
        acc(1'b0, 8'h10, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000)
        reg_rd(8'h20, rd);
        `CHK(rd, 32'h0000_0000)
        reg_wr(`LIC_RES0_OFF, 32'h0000_0000);
        reg_rd(`LIC_RES0_OFF, rd);
        `CHK(rd, {27'h000_0000, 5'(avg[0][0] >> 8)})
        acc(1'b0, `LIC_INDEX_OFF, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0034)
        $display("test refuse done");
        for (int i = 0; i < 10; i++) begin
            run_once(i % 2);
        end
        $display("test average done");
        @(negedge i_clk);
        i_srst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_srst = 1'b0;
        reg_rd(`LIC_CTRL1_OFF, rd);
        `CHK(rd, 32'h0000_0502)
        reg_rd(`LIC_RES0_OFF, rd);
        `CHK(rd, 32'h0000_ffff)
        $display("test rereset done");
        end_of_test();
    end
endmodule
